/* verilog/spimsp_defines.vh */
/*
 * Constants for the byte-wide serial port: register addresses, control bit
 * positions, reset values and shift-engine counts.
 * Assumes it is included by bare name into the serial port design files.
 */
`ifndef SPIMSP_DEFINES_VH
`define SPIMSP_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------------
`define SPIMSP_ADDR_DATA     8'h7F
`define SPIMSP_ADDR_CTRL     8'hF8
`define SPIMSP_DATA_RESET    8'h00
`define SPIMSP_CTRL_RESET    8'h05

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define SPIMSP_BIT_DONE      7
`define SPIMSP_BIT_WRITE_COLLISION_FLAG      6
`define SPIMSP_BIT_ENABLE    5
`define SPIMSP_BIT_MASTER    4
`define SPIMSP_BIT_IDLE      3
`define SPIMSP_BIT_PHASE     2
`define SPIMSP_BIT_RATE_HI   1
`define SPIMSP_BIT_RATE_LO   0

// ----------------------------------------------------------------------
// Shift engine
// ----------------------------------------------------------------------
`define SPIMSP_BITS_PER_BYTE 4'h8
`define SPIMSP_LAST_EDGE     4'hF
`define SPIMSP_MSB           7
`define SPIMSP_HALF_W        3

`endif

/* verilog/spimsp_rate_div.v */
/*
 * Half-period enable generator for the master serial clock.
 * Assumes a single core clock; the rate code is held stable by software
 * while a transfer runs, and run is low between transfers.
 */
`timescale 1ns/100ps
`default_nettype none
`include "spimsp_defines.vh"

module spimsp_rate_div (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Control
    input  wire       run,
    input  wire [1:0] rate_code,
    // Output
    output wire       half_tick
);

    reg  [`SPIMSP_HALF_W-1:0] count_reg;
    wire [`SPIMSP_HALF_W-1:0] limit;

    // Divide by 2, 4, 8, 16 means a half period of 1, 2, 4, 8 core cycles.
    assign limit     = (3'h1 << rate_code) - 3'h1;
    assign half_tick = run && (count_reg == limit);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 3'h0;
        end else if (!run || half_tick) begin
            count_reg <= 3'h0;
        end else begin
            count_reg <= count_reg + 3'h1;
        end
    end

endmodule
`default_nettype wire

/* verilog/spimsp_port.v */
/*
 * Byte-wide full-duplex serial port, master or slave, with its control and
 * data registers on the core's special register port.
 * Assumes one core clock; all pin inputs are synchronised here, and the
 * pin multiplexer outside uses pins_enabled to choose port or serial use.
 */
// Functional notes
// - Transfer-done flag bit 7 set per byte.
// - Done cleared by write zero or data read.
// - Data write during transfer sets collision bit 6.
// - Bit 5 gives pins to serial port.
// - Bit 4 selects master, clock pin output.
// - Bit 3 sets idle clock level.
// - Bit 2 chooses leading or trailing launch.
// - Rate bits divide core clock 2..16.
// - Master data write gives eight clocks.
// - Master shifts MOSI, samples MISO each period.
// - Master ignores select input.
// - Master copies receive byte, sets done.
// - Interrupt request only when enabled.
// - Slave loads byte by write; shifts per clock.
// - Slave ends on eighth clock with phase one, on select high after the byte with phase zero.
// - Interrupt shares vector with other port.
// - Eight bits, MSB first, both directions.
// - Slave reads select level in rate_lo.
`timescale 1ns/100ps
`default_nettype none
`include "spimsp_defines.vh"

module spimsp_port (
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Special register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // Interrupt
    input  wire       irq_enable,
    output wire       irq_req,
    // Pins
    input  wire       sclk_in,
    output reg        sclk_out,
    output wire       sclk_oe,
    input  wire       mosi_in,
    output reg        mosi_out,
    output wire       mosi_oe,
    input  wire       miso_in,
    output reg        miso_out,
    output wire       miso_oe,
    input  wire       slave_sel_n,
    output wire       pins_enabled
);

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_MRUN = 2'h1;
    localparam ST_SRUN = 2'h2;
    localparam ST_MEND = 2'h3;

    reg  [7:0] ctrl_reg;
    reg  [7:0] data_reg;
    reg  [7:0] tx_reg;
    reg  [7:0] rx_reg;
    reg  [3:0] edge_cnt_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [1:0] state_reg;
    reg  [1:0] cap_pipe_reg;
    reg  [1:0] sclk_sync_reg;
    reg  [1:0] ss_sync_reg;
    reg  [1:0] mosi_sync_reg;
    reg  [1:0] miso_sync_reg;
    reg        sclk_prev_reg;
    reg        ss_prev_reg;

    wire       enabled    = ctrl_reg[`SPIMSP_BIT_ENABLE];
    wire       is_master  = ctrl_reg[`SPIMSP_BIT_MASTER];
    wire       idle_level = ctrl_reg[`SPIMSP_BIT_IDLE];
    wire       phase      = ctrl_reg[`SPIMSP_BIT_PHASE];
    wire       busy       = (state_reg != ST_IDLE);
    wire       wr_ctrl    = reg_wr && (reg_addr == `SPIMSP_ADDR_CTRL);
    wire       wr_data    = reg_wr && (reg_addr == `SPIMSP_ADDR_DATA);
    wire       rd_data    = reg_rd && (reg_addr == `SPIMSP_ADDR_DATA);
    wire       half_tick;

    // Only the second synchroniser stage is ever looked at.
    wire       sclk_s = sclk_sync_reg[1];
    wire       ss_s   = ss_sync_reg[1];
    wire       mosi_s = mosi_sync_reg[1];
    wire       miso_s = miso_sync_reg[1];

    // ------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------
    assign pins_enabled = enabled;
    assign sclk_oe = enabled && is_master;
    assign mosi_oe = enabled && is_master;
    // Slave drives MISO only while selected, so several slaves can share it.
    assign miso_oe = enabled && !is_master && !ss_s;
    assign irq_req = irq_enable && ctrl_reg[`SPIMSP_BIT_DONE];

    spimsp_rate_div u_div (
        .clk       (clk),
        .resetn    (resetn),
        .run       (state_reg == ST_MRUN),
        .rate_code (ctrl_reg[`SPIMSP_BIT_RATE_HI:`SPIMSP_BIT_RATE_LO]),
        .half_tick (half_tick)
    );

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_sync_reg <= 2'h0;
            ss_sync_reg   <= 2'h3;
            mosi_sync_reg <= 2'h0;
            miso_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
            ss_prev_reg   <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
            ss_sync_reg   <= {ss_sync_reg[0], slave_sel_n};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
            miso_sync_reg <= {miso_sync_reg[0], miso_in};
            sclk_prev_reg <= sclk_s;
            ss_prev_reg   <= ss_s;
        end
    end

    // Slave clock edges, named relative to the idle level.
    wire s_edge    = (sclk_s != sclk_prev_reg) && !ss_s;
    wire s_leading = s_edge && (sclk_s != idle_level);
    wire s_trail   = s_edge && (sclk_s == idle_level);
    wire ss_rise   = ss_s && !ss_prev_reg;

    // Launch and sample edges: phase one launches on the leading edge.
    wire s_launch  = phase ? s_leading : s_trail;
    wire s_sample  = phase ? s_trail : s_leading;

    // ------------------------------------------------------------------
    // Shift engine and registers
    // ------------------------------------------------------------------
    reg       done_set;
    reg       m_edge;
    reg       m_sample;
    reg [7:0] done_byte;

    always @* begin
        done_set  = 1'b0;
        done_byte = rx_reg;
        m_edge    = (state_reg == ST_MRUN) && half_tick;
        m_sample  = m_edge && (edge_cnt_reg[0] == phase);
        // The master ends only once every delayed MISO capture has landed.
        if (state_reg == ST_MEND && cap_pipe_reg == 2'h0 && enabled && is_master) begin
            done_set = 1'b1;
        end
        if (state_reg == ST_SRUN) begin
            if (phase && s_sample && bit_cnt_reg == `SPIMSP_BITS_PER_BYTE - 4'h1) begin
                // The eighth bit is still on its way into rx_reg, so it is committed directly.
                done_set  = 1'b1;
                done_byte = {rx_reg[6:0], mosi_s};
            end
            if (!phase && ss_rise && bit_cnt_reg == `SPIMSP_BITS_PER_BYTE) begin
                done_set = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg     <= `SPIMSP_CTRL_RESET;
            data_reg     <= `SPIMSP_DATA_RESET;
            tx_reg       <= 8'h00;
            rx_reg       <= 8'h00;
            edge_cnt_reg <= 4'h0;
            bit_cnt_reg  <= 4'h0;
            state_reg    <= ST_IDLE;
            cap_pipe_reg <= 2'h0;
            sclk_out     <= 1'b0;
            mosi_out     <= 1'b0;
            miso_out     <= 1'b0;
        end else begin
            // Control register writes; hardware sets win over clears.
            if (wr_ctrl) begin
                ctrl_reg[5:0] <= reg_wdata[5:0];
                if (!reg_wdata[`SPIMSP_BIT_DONE]) begin
                    ctrl_reg[`SPIMSP_BIT_DONE] <= 1'b0;
                end
                if (!reg_wdata[`SPIMSP_BIT_WRITE_COLLISION_FLAG]) begin
                    ctrl_reg[`SPIMSP_BIT_WRITE_COLLISION_FLAG] <= 1'b0;
                end
            end
            if (rd_data) begin
                ctrl_reg[`SPIMSP_BIT_DONE] <= 1'b0;
            end
            if (wr_data && busy) begin
                ctrl_reg[`SPIMSP_BIT_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (done_set) begin
                ctrl_reg[`SPIMSP_BIT_DONE] <= 1'b1;
                data_reg <= done_byte;
            end
            if (!busy) begin
                sclk_out <= idle_level;
            end
            // MISO passes two flip-flops, so each master sample is taken two
            // cycles after its edge. At divide by two the next launch edge
            // would otherwise replace the bit before the core saw it.
            cap_pipe_reg <= {cap_pipe_reg[0], m_sample};
            if (cap_pipe_reg[1]) begin
                rx_reg <= {rx_reg[6:0], miso_s};
            end

            case (state_reg)
                ST_IDLE: begin
                    if (wr_data && enabled) begin
                        data_reg     <= reg_wdata;
                        tx_reg       <= reg_wdata;
                        edge_cnt_reg <= 4'h0;
                        bit_cnt_reg  <= 4'h0;
                        if (is_master) begin
                            // Select is never consulted in master mode.
                            state_reg <= ST_MRUN;
                            if (!phase) begin
                                mosi_out <= reg_wdata[`SPIMSP_MSB];
                            end
                        end else begin
                            state_reg <= ST_SRUN;
                            if (!phase) begin
                                miso_out <= reg_wdata[`SPIMSP_MSB];
                            end
                        end
                    end
                end
                ST_MRUN: begin
                    if (!enabled || !is_master) begin
                        state_reg <= ST_IDLE;
                    end else if (m_edge) begin
                        // Sixteen half periods make the eight clock periods.
                        sclk_out     <= ~sclk_out;
                        edge_cnt_reg <= edge_cnt_reg + 4'h1;
                        if (m_sample) begin
                            // Sample edge: MISO is captured later, the byte moves on now.
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end else if (phase || edge_cnt_reg != `SPIMSP_LAST_EDGE) begin
                            // Launch edge; phase zero has no launch after the last bit.
                            mosi_out <= tx_reg[`SPIMSP_MSB];
                        end
                        if (edge_cnt_reg == `SPIMSP_LAST_EDGE) begin
                            state_reg <= ST_MEND;
                        end
                    end
                end
                ST_MEND: begin
                    // Busy is held until the last delayed capture is in, so a
                    // new write in this gap still counts as a collision.
                    if (!enabled || !is_master || cap_pipe_reg == 2'h0) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SRUN: begin
                    // Master keeps select low across the byte.
                    if (!enabled || is_master) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        if (s_launch && (phase || bit_cnt_reg != 4'h0)) begin
                            miso_out <= tx_reg[`SPIMSP_MSB];
                        end
                        if (s_sample) begin
                            rx_reg      <= {rx_reg[6:0], mosi_s};
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        // Phase zero waits for select to rise after the byte.
                        if (done_set) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always @* begin
        reg_rdata = 8'h00;
        if (reg_addr == `SPIMSP_ADDR_CTRL) begin
            reg_rdata = ctrl_reg;
            if (!is_master) begin
                reg_rdata[`SPIMSP_BIT_RATE_LO] = ss_s;
            end
        end else if (reg_addr == `SPIMSP_ADDR_DATA) begin
            reg_rdata = data_reg;
        end
    end

endmodule
`default_nettype wire

/* verification/spimsp_port_monitor.sv */
/* Checker for spimsp_port: pin enables, flags and interrupt.
   Assumes it is bound to every spimsp_port instance. */
`timescale 1ns/100ps
`default_nettype none
module spimsp_port_monitor (
    // Clock and registers
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Interrupt and pins
    input wire logic       irq_enable,
    input wire logic       irq_req,
    input wire logic       sclk_oe,
    input wire logic       mosi_oe,
    input wire logic       miso_oe,
    input wire logic       slave_sel_n,
    input wire logic       pins_enabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire ctl = reg_addr == 8'hF8;
    chk_irq_gate: assert property (ctl |-> irq_req == (irq_enable & reg_rdata[7]))
        else $error("irq differs from flag");
    chk_pins_given: assert property (ctl |-> pins_enabled == reg_rdata[5])
        else $error("pin choice wrong");
    chk_sclk_dir: assert property (ctl |-> sclk_oe == (reg_rdata[5] & reg_rdata[4]))
        else $error("clock direction wrong");
    chk_mosi_dir: assert property (mosi_oe == sclk_oe)
        else $error("data out direction wrong");
    chk_miso_master: assert property (sclk_oe |-> !miso_oe)
        else $error("master drives miso");
    chk_miso_unsel: assert property ($stable(slave_sel_n)[*3] ##0 slave_sel_n |-> !miso_oe)
        else $error("unselected slave drives");
    chk_sel_level: assert property ($stable(slave_sel_n)[*3] ##0 (ctl && reg_rdata[5:4] == 2'b10)
        |-> reg_rdata[0] == slave_sel_n)
        else $error("select level not read");
    chk_flag_hold: assert property (irq_req && !reg_wr && !reg_rd ##1 irq_enable |-> irq_req)
        else $error("flag lost");
    cover property ($rose(irq_req) && sclk_oe);
    cover property ($rose(irq_req) && !sclk_oe);
    cover property ($rose(miso_oe));
endmodule
bind spimsp_port spimsp_port_monitor i_spimsp_port_monitor (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_enable(irq_enable), .irq_req(irq_req), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .slave_sel_n(slave_sel_n), .pins_enabled(pins_enabled));
`default_nettype wire

/* verification/spimsp_far_end.sv */
/* Far-end serial slave that answers the port in master mode.
   Assumes the bench gives it the port's polarity and phase. */
`timescale 1ns/100ps
`default_nettype none
module spimsp_far_end (
    // Mode and byte
    input  wire logic       clock_idle_level,
    input  wire logic       clock_phase_select,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output var  logic [7:0] rx_byte,
    // Pins
    input  wire logic       sel_n,
    input  wire logic       sclk,
    input  wire logic       mosi,
    output wire logic       miso
);
    logic [8:0] sh = 9'h000;
    logic       last = 1'b0;
    initial rx_byte = 8'h00;
    // Unselected, the line flips rather than holding a value that could pass by luck.
    assign miso = sel_n ? ~last : sh[8];
    always @(posedge load) sh = clock_phase_select ? {1'b0, tx_byte} : {tx_byte, 1'b0};
    always @(sclk) begin
        if (!sel_n && ((sclk != clock_idle_level) == clock_phase_select)) begin
            last = sh[8];
            sh = {sh[7:0], 1'b0};
        end else if (!sel_n) begin
            rx_byte = {rx_byte[6:0], mosi};
        end
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
/* Bench for spimsp_port: registers, master and slave bytes, collision.
   Assumes the far-end model answers master transfers. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_enable = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, far_tx = 8'h00, got;
    logic       m_sclk = 1'b0, m_mosi = 1'b0, sel_n = 1'b1, far_sel_n = 1'b1;
    logic       clock_idle_level = 1'b0, clock_phase_select = 1'b0, load = 1'b0;
    wire  [7:0] far_rx, reg_rdata;
    wire        sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq_req, pins_enabled, far_miso;
    wire        sclk = sclk_oe ? sclk_out : m_sclk;
    wire        mosi = mosi_oe ? mosi_out : m_mosi;
    wire        miso = miso_oe ? miso_out : far_miso;
    int         errors = 0, compares = 0, tog, cyc, i, c;
    spimsp_port i_spimsp_port (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_enable(irq_enable),
        .irq_req(irq_req), .sclk_in(sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out),
        .miso_oe(miso_oe), .slave_sel_n(sel_n), .pins_enabled(pins_enabled));
    spimsp_far_end i_spimsp_far_end (.clock_idle_level(clock_idle_level), .clock_phase_select(clock_phase_select), .load(load), .tx_byte(far_tx),
        .rx_byte(far_rx), .sel_n(far_sel_n), .sclk(sclk), .mosi(mosi), .miso(far_miso));
    initial forever #2 clk = ~clk;
    // Counts clock toggles so that a short or long burst shows up.
    always @(sclk_out) tog++;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic results;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        #1 chk(reg_rdata, e);
        @(negedge clk);
        reg_rd = 1'b0;
    endtask
    task automatic wait_irq(input int lim);
        for (cyc = 1; cyc <= lim && irq_req !== 1'b1; cyc++) begin
            @(negedge clk);
        end
        if (irq_req !== 1'b1) begin
            errors++;
            results();
        end
    endtask
    task automatic mxfer(input logic [7:0] ctl, input logic [7:0] mo, input logic [7:0] so, input bit hit);
        m_sclk = ctl[3];
        wr(8'hF8, ctl);
        clock_idle_level = ctl[3];
        clock_phase_select = ctl[2];
        far_tx = so;
        repeat (4) @(negedge clk);
        tog = 0;
        load = 1'b1;
        far_sel_n = 1'b0;
        wr(8'h7F, mo);
        load = 1'b0;
        if (hit) begin
            repeat (20) @(negedge clk);
            wr(8'h7F, 8'hFF);
        end
        wait_irq(600);
        far_sel_n = 1'b1;
        chk(8'(tog), 8'h10);
        chk(far_rx, mo);
    endtask
    task automatic sbyte(input logic ph, input logic [7:0] mo);
        got = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (ph) m_sclk = 1'b1;
            m_mosi = mo[b];
            repeat (12) @(negedge clk);
            m_sclk = ~m_sclk;
            got = {got[6:0], miso};
            repeat (12) @(negedge clk);
            if (!ph) m_sclk = 1'b0;
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        rdc(8'hF8, 8'h05);
        rdc(8'h7F, 8'h00);
        rdc(8'h00, 8'h00);
        for (i = 0; i < 4; i++) begin
            sel_n = i[0];
            mxfer(8'h30 | 8'(i * 5), 8'hA5 ^ 8'(i), 8'h3C + 8'(i), 1'b0);
            chk({7'h00, cyc - 1 >= (16 << i) && cyc - 1 <= (16 << i) + 6}, 8'h01);
            chk({7'h00, sclk_out}, {7'h00, clock_idle_level});
            rdc(8'hF8, 8'hB0 | 8'(i * 5));
            rdc(8'h7F, 8'h3C + 8'(i));
            rdc(8'hF8, 8'h30 | 8'(i * 5));
        end
        sel_n = 1'b1;
        mxfer(8'h33, 8'h5A, 8'h81, 1'b1);
        rdc(8'hF8, 8'hF3);
        irq_enable = 1'b0;
        #1 chk({7'h00, irq_req}, 8'h00);
        irq_enable = 1'b1;
        wr(8'hF8, 8'h33);
        rdc(8'hF8, 8'h33);
        wr(8'hF8, 8'h10);
        chk({6'h00, pins_enabled, sclk_oe}, 8'h00);
        wr(8'h7F, 8'h77);
        rdc(8'h7F, 8'h81);
        for (c = 0; c < 2; c++) begin
            m_sclk = 1'b0;
            wr(8'hF8, 8'h21 | 8'(c * 4));
            wr(8'h7F, 8'h3C);
            sel_n = 1'b0;
            repeat (4) @(negedge clk);
            rdc(8'hF8, 8'h20 | 8'(c * 4));
            sbyte(c[0], 8'hC3);
            chk(got, 8'h3C);
            if (c == 0) begin
                repeat (12) @(negedge clk);
                chk({7'h00, irq_req}, 8'h00);
                sel_n = 1'b1;
            end
            wait_irq(40);
            rdc(8'h7F, 8'hC3);
            sel_n = 1'b1;
            repeat (4) @(negedge clk);
            rdc(8'hF8, 8'h21 | 8'(c * 4));
        end
        results();
    end
endmodule
`default_nettype wire
